/* pts_defines.svh */
// Purpose: Offsets, codes and sizes for the time stamp rewrite path
// Assumes: Untagged Ethernet frames, byte offsets counted from destination MAC
// Notes:   Definitions only
`ifndef PTS_DEFINES_SVH
`define PTS_DEFINES_SVH

`define PTS_DELAY       32
`define PTS_CNT_MAX     11'h7ff
`define PTS_ETYPE_PTP   16'h88f7
`define PTS_ETYPE_OAM   16'h8902
`define PTS_OFF_ETYPE_H 11'h00c
`define PTS_OFF_ETYPE_L 11'h00d
`define PTS_OFF_MSG     11'h00e
`define PTS_OFF_OPC     11'h00f
`define PTS_OFF_DOM     11'h012
`define PTS_OFF_FLG_H   11'h014
`define PTS_OFF_FLG_L   11'h015
`define PTS_OFF_CF      11'h016
`define PTS_OFF_CF_END  11'h01d
`define PTS_OFF_RES     11'h01e
`define PTS_OFF_RES_END 11'h021
`define PTS_OFF_SEQ_H   11'h02c
`define PTS_OFF_SEQ_L   11'h02d
`define PTS_OFF_DECIDE  11'h02e
`define PTS_OFF_TXF     11'h012
`define PTS_OFF_RXF     11'h01a
`define PTS_OFF_TXB     11'h022
`define PTS_OFF_RXB     11'h02a
`define PTS_MSG_SYNC    4'h0
`define PTS_MSG_DREQ    4'h1
`define PTS_OPC_1DM     8'h2d
`define PTS_OPC_DMT     8'h2e
`define PTS_OPC_DMM     8'h2f
`define PTS_SZ_NONE     4'h0
`define PTS_SZ_RES      4'h4
`define PTS_SZ_TS       4'h8
`define PTS_CRC_POLY    32'hedb88320
`define PTS_CRC_INIT    32'hffffffff
`define PTS_FIFO_DEPTH  8
`define PTS_ID_W        80
`define PTS_TS_W        64
`define PTS_SET_W       144
`define PTS_LANE_W      10

`endif

/* pts_pkg.sv */
// Purpose: Types shared by the time stamp rewrite path
// Assumes: Nothing
// Notes:   Actions are one-hot
package pts_pkg;
	typedef enum logic [2:0] {
		PTS_ACT_NONE  = 3'b001,
		PTS_ACT_WRITE = 3'b010,
		PTS_ACT_WSAVE = 3'b100
	} pts_act_e;
	typedef logic [7:0] pts_byte_t;
endpackage

/* pts_strm_if.sv */
// Purpose: Valid/ready word carrier between path modules
// Assumes: One clock
// Notes:   Width set per instance
`timescale 1ns/1ns
interface pts_strm_if #(parameter int W = 8) ();
	logic         valid;
	logic         ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

/* pts_skid_buf.sv */
// Purpose: Two-entry buffer in front of the frame output
// Assumes: Producer pushes only while ready is high
// Notes:   Every output is a flop
`timescale 1ns/1ns
`include "pts_defines.svh"
module pts_skid_buf (
	input  wire logic                   clk_in,    // Clock
	input  wire logic                   rst_b_in,  // Async reset, low
	pts_strm_if.snk                     up,        // Filling side
	output logic                        valid_out, // Head valid
	output logic [`PTS_LANE_W-1:0]      data_out,  // Head word
	input  wire logic                   ready_in   // Drain ready
);
	logic                   spare_v_q;
	logic [`PTS_LANE_W-1:0] spare_q;
	logic                   ready_q;
	logic                   push;
	logic                   pop;
	logic                   spare_v_d;

	assign up.ready = ready_q;
	assign push     = up.valid & ready_q;
	assign pop      = valid_out & ready_in;

	always_comb begin
		spare_v_d = spare_v_q;
		if (pop) begin
			spare_v_d = spare_v_q & push;
		end else if (push && valid_out) begin
			spare_v_d = 1'b1;
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			valid_out <= 1'b0;
			data_out  <= '0;
			spare_v_q <= 1'b0;
			spare_q   <= '0;
			ready_q   <= 1'b1;
		end else begin
			spare_v_q <= spare_v_d;
			ready_q   <= ~spare_v_d;
			if (pop && spare_v_q) begin
				data_out <= spare_q;
				if (push) begin
					spare_q <= up.data;
				end
			end else if (pop || !valid_out) begin
				valid_out <= push;
				if (push) begin
					data_out <= up.data;
				end
			end else if (push) begin
				spare_q <= up.data;
			end
		end
	end

	property p_buf_hold;
		@(posedge clk_in) disable iff (!rst_b_in)
		valid_out && !ready_in |=> valid_out && $stable(data_out);
	endproperty
	a_buf_hold: assert property (p_buf_hold) else $error("head word not held while stalled");
endmodule

/* pts_ts_fifo.sv */
// Purpose: Transmit time stamp store read by the processor
// Assumes: Read strobe is one cycle per set
// Notes:   A push while full is not taken
`timescale 1ns/1ns
`include "pts_defines.svh"
module pts_ts_fifo (
	input  wire logic                 clk_in,     // Clock
	input  wire logic                 rst_b_in,   // Async reset, low
	pts_strm_if.snk                   wr,         // Identifier plus time set
	input  wire logic                 rd_in,      // Processor read strobe
	output logic [`PTS_SET_W-1:0]     rd_data_out, // Set read out
	output logic                      rd_valid_out, // Read answer pulse
	output logic                      empty_out   // No set stored
);
	logic [`PTS_SET_W-1:0] mem [0:`PTS_FIFO_DEPTH-1];
	logic [2:0]            wp_q;
	logic [2:0]            rp_q;
	logic [3:0]            cnt_q;
	logic                  push;
	logic                  pop;

	assign wr.ready = (cnt_q != 4'h8);
	assign push     = wr.valid & wr.ready;
	assign pop      = rd_in & (cnt_q != 4'h0);

	always_ff @(posedge clk_in) begin
		if (push) begin
			mem[wp_q] <= wr.data;
		end
	end

	// Pointers, count and processor read port
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			wp_q         <= 3'h0;
			rp_q         <= 3'h0;
			cnt_q        <= 4'h0;
			rd_data_out  <= '0;
			rd_valid_out <= 1'b0;
			empty_out    <= 1'b1;
		end else begin
			rd_valid_out <= pop;
			if (push) begin
				wp_q <= wp_q + 3'h1;
			end
			if (pop) begin
				rp_q        <= rp_q + 3'h1;
				rd_data_out <= mem[rp_q];
			end
			cnt_q     <= cnt_q + {3'h0, push} - {3'h0, pop};
			empty_out <= (cnt_q + {3'h0, push} - {3'h0, pop}) == 4'h0;
		end
	end
endmodule

/* pts_ts_path.sv */
// Purpose: One direction of frame time stamp action: analyzer, stamp, rewriter
// Assumes: Byte stream with sof/eof, frames of at least 64 bytes, untagged
// Notes:   Data is delayed so the decision is ready before the first target byte
// Contract
// - Ingress in-domain Sync or Delay_req: Write into the four reserved header bytes.
// - Ingress Write places nanoseconds into reserved bytes and FCS is recomputed.
// - Ingress reserved value is ns minus correction; Sync correction field gains asymmetry.
// - Egress in-domain Sync or Delay_req: Write-and-Save with no stamp written in frame.
// - Egress frame identifier to the FIFO includes the sequence identifier.
// - Egress clears the reserved header bytes to zero.
// - Write-and-Save drives zero to the rewriter, time to the FIFO and raises the save flag.
// - FIFO stores the time with identifier holding the reserved ingress time.
// - Egress FIFO time is ns plus correction; Delay_req also subtracts asymmetry.
// - Ingress 1DM of the MEP: write ns minus correction at RxTimeStampf.
// - Egress 1DM and DMM: write ns plus correction at TxTimeStampf.
// - Ingress DMM of the MEP: write ns minus correction at RxTimeStampf.
// - Ingress DMT of the MEP: write ns minus correction at RxTimeStampb.
// - Egress DMT of the MEP: write ns plus correction at TxTimeStampb.
// - Delay frames get the stamp in the indicated bytes and a new FCS.
// - Unmatched frames pass unmodified and their held stamp is dropped.
// - The FIFO offers a processor read port for stored sets.
`timescale 1ns/1ns
`include "pts_defines.svh"
module pts_ts_path
	import pts_pkg::*;
(
	input  wire logic                 clk_in,        // 100 MHz clock
	input  wire logic                 rst_b_in,      // Async reset, low
	input  wire logic                 egress_in,     // 1 egress, 0 ingress
	input  wire logic [7:0]           domain_in,     // Accepted PTP domain
	input  wire logic [2:0]           mep_level_in,  // MEP level
	input  wire logic [31:0]          local_corr_in, // Local correction, ns
	input  wire logic [31:0]          asym_in,       // Asymmetry, ns
	input  wire logic [31:0]          time_sec_in,   // Local time seconds
	input  wire logic [31:0]          time_ns_in,    // Local time nanoseconds
	input  wire logic                 in_valid_in,   // Input byte valid
	input  wire logic [7:0]           in_data_in,    // Input byte
	input  wire logic                 in_sof_in,     // First byte of frame
	input  wire logic                 in_eof_in,     // Last byte of frame
	output logic                      in_ready_out,  // Input accepted
	output logic                      out_valid_out, // Output byte valid
	output logic [7:0]                out_data_out,  // Output byte
	output logic                      out_sof_out,   // Output first byte
	output logic                      out_eof_out,   // Output last byte
	input  wire logic                 out_ready_in,  // Receiver ready
	output logic                      save_ts_out,   // Save flag pulse
	input  wire logic                 fifo_rd_in,    // FIFO read strobe
	output logic [`PTS_SET_W-1:0]     fifo_data_out, // {id, sec, ns}
	output logic                      fifo_valid_out, // FIFO read answer
	output logic                      fifo_empty_out // FIFO empty
);
	localparam int D = `PTS_DELAY;

	pts_strm_if #(.W(`PTS_LANE_W)) buf_if ();
	pts_strm_if #(.W(`PTS_SET_W))  fifo_if ();

	logic [7:0]               ln_d [0:D-1];
	logic [D-1:0]             ln_s;
	logic [D-1:0]             ln_e;
	logic [D-1:0]             ln_v;
	logic                     adv;
	logic                     acc;
	logic [10:0]              a_cnt;
	logic [10:0]              idx;
	logic [15:0]              a_et;
	logic [7:0]               a_msg;
	logic [7:0]               a_opc;
	logic [7:0]               a_dom;
	logic [15:0]              a_flg;
	logic [63:0]              a_cf;
	logic [31:0]              a_res;
	logic [15:0]              a_seq;
	logic [31:0]              ts_sec_q;
	logic [31:0]              ts_ns_q;
	logic                     decide;
	logic                     is_ptp;
	logic                     is_oam;
	logic                     is_sync;
	logic [31:0]              ns_minus;
	logic [31:0]              ns_plus;
	logic [63:0]              asym_cf;
	pts_act_e                 r_act;
	logic [10:0]              r_off;
	logic [3:0]               r_size;
	logic [63:0]              r_val;
	logic                     r_cf_en;
	logic [63:0]              r_cf;
	logic                     save_q;
	logic                     push_q;
	logic [`PTS_SET_W-1:0]    push_d_q;
	logic [10:0]              r_cnt;
	logic [10:0]              ridx;
	pts_act_e                 act_cur;
	logic [31:0]              crc_q;
	logic [31:0]              crc_cur;
	logic                     fcs;
	logic [1:0]               fcs_j;
	logic                     in_a;
	logic                     in_cf;
	logic [10:0]              a_rel;
	logic [3:0]               a_k;
	logic [2:0]               cf_k;
	logic [7:0]               rw_byte;

	function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] b);
		logic [31:0] r;
		r = c ^ {24'h0, b};
		for (int i = 0; i < 8; i++) begin
			r = r[0] ? ((r >> 1) ^ `PTS_CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction

	// Stream moves only when the output buffer can take a word
	assign adv          = in_ready_out & (in_valid_in | (|ln_v));
	assign acc          = adv & in_valid_in;
	assign buf_if.valid = adv & ln_v[D-1];
	assign buf_if.data  = {ln_s[D-1], ln_e[D-1], rw_byte};
	assign in_ready_out = buf_if.ready;
	assign fifo_if.valid = push_q;
	assign fifo_if.data  = push_d_q;
	assign save_ts_out   = save_q;

	// Delay line ahead of the rewriter
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ln_s <= '0;
			ln_e <= '0;
			ln_v <= '0;
		end else if (adv) begin
			ln_s <= {ln_s[D-2:0], in_sof_in & in_valid_in};
			ln_e <= {ln_e[D-2:0], in_eof_in & in_valid_in};
			ln_v <= {ln_v[D-2:0], in_valid_in};
		end
	end

	always_ff @(posedge clk_in) begin
		if (adv) begin
			ln_d[0] <= in_data_in;
			for (int i = 1; i < D; i++) begin
				ln_d[i] <= ln_d[i-1];
			end
		end
	end

	// Analyzer byte position and field capture
	assign idx = in_sof_in ? 11'h000 : a_cnt;

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			a_cnt <= 11'h000;
		end else if (acc) begin
			a_cnt <= (idx == `PTS_CNT_MAX) ? idx : idx + 11'h001;
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			a_et  <= 16'h0000;
			a_msg <= 8'h00;
			a_opc <= 8'h00;
			a_dom <= 8'h00;
			a_flg <= 16'h0000;
			a_cf  <= 64'h0;
			a_res <= 32'h0;
			a_seq <= 16'h0000;
		end else if (acc) begin
			if (idx == `PTS_OFF_ETYPE_H || idx == `PTS_OFF_ETYPE_L) begin
				a_et <= {a_et[7:0], in_data_in};
			end else if (idx == `PTS_OFF_MSG) begin
				a_msg <= in_data_in;
			end else if (idx == `PTS_OFF_OPC) begin
				a_opc <= in_data_in;
			end else if (idx == `PTS_OFF_DOM) begin
				a_dom <= in_data_in;
			end else if (idx == `PTS_OFF_FLG_H || idx == `PTS_OFF_FLG_L) begin
				a_flg <= {a_flg[7:0], in_data_in};
			end else if (idx >= `PTS_OFF_CF && idx <= `PTS_OFF_CF_END) begin
				a_cf <= {a_cf[55:0], in_data_in};
			end else if (idx >= `PTS_OFF_RES && idx <= `PTS_OFF_RES_END) begin
				a_res <= {a_res[23:0], in_data_in};
			end else if (idx == `PTS_OFF_SEQ_H || idx == `PTS_OFF_SEQ_L) begin
				a_seq <= {a_seq[7:0], in_data_in};
			end
		end
	end

	// Local time caught at start of frame
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ts_sec_q <= 32'h0;
			ts_ns_q  <= 32'h0;
		end else if (acc && in_sof_in) begin
			ts_sec_q <= time_sec_in;
			ts_ns_q  <= time_ns_in;
		end
	end

	assign decide   = acc & (idx == `PTS_OFF_DECIDE);
	assign is_sync  = (a_msg[3:0] == `PTS_MSG_SYNC);
	assign is_ptp   = (a_et == `PTS_ETYPE_PTP) && (a_dom == domain_in) &&
	                  (is_sync || a_msg[3:0] == `PTS_MSG_DREQ);
	assign is_oam   = (a_et == `PTS_ETYPE_OAM) && (a_msg[7:5] == mep_level_in) &&
	                  (a_opc == `PTS_OPC_1DM || a_opc == `PTS_OPC_DMM || a_opc == `PTS_OPC_DMT);
	assign ns_minus = ts_ns_q - local_corr_in;
	assign ns_plus  = ts_ns_q + local_corr_in;
	// Correction field carries ns scaled by 2^16
	assign asym_cf  = {{16{asym_in[31]}}, asym_in, 16'h0000};

	// Time stamp block: action, target and value for the rewriter
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			r_act   <= PTS_ACT_NONE;
			r_off   <= 11'h000;
			r_size  <= `PTS_SZ_NONE;
			r_val   <= 64'h0;
			r_cf_en <= 1'b0;
			r_cf    <= 64'h0;
		end else if (adv && ln_v[D-1] && ln_s[D-1]) begin
			r_act   <= PTS_ACT_NONE;
			r_size  <= `PTS_SZ_NONE;
			r_cf_en <= 1'b0;
		end else if (decide) begin
			r_cf_en <= 1'b0;
			if (is_ptp && !egress_in) begin
				r_act   <= PTS_ACT_WRITE;
				r_off   <= `PTS_OFF_RES;
				r_size  <= `PTS_SZ_RES;
				r_val   <= {32'h0, ns_minus};
				r_cf_en <= is_sync;
				r_cf    <= a_cf + asym_cf;
			end else if (is_ptp) begin
				r_act  <= PTS_ACT_WSAVE;
				r_off  <= `PTS_OFF_RES;
				r_size <= `PTS_SZ_RES;
				r_val  <= 64'h0;
			end else if (is_oam && !egress_in) begin
				r_act  <= PTS_ACT_WRITE;
				r_off  <= (a_opc == `PTS_OPC_DMT) ? `PTS_OFF_RXB : `PTS_OFF_RXF;
				r_size <= `PTS_SZ_TS;
				r_val  <= {ts_sec_q, ns_minus};
			end else if (is_oam) begin
				r_act  <= PTS_ACT_WRITE;
				r_off  <= (a_opc == `PTS_OPC_DMT) ? `PTS_OFF_TXB : `PTS_OFF_TXF;
				r_size <= `PTS_SZ_TS;
				r_val  <= {ts_sec_q, ns_plus};
			end else begin
				r_act  <= PTS_ACT_NONE;
				r_size <= `PTS_SZ_NONE;
			end
		end
	end

	// Save path into the transmit stamp store
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			push_q   <= 1'b0;
			save_q   <= 1'b0;
			push_d_q <= '0;
		end else begin
			push_q <= decide & is_ptp & egress_in;
			save_q <= decide & is_ptp & egress_in;
			if (decide) begin
				// Identifier: type, domain, sequence id, ingress stamp, flags
				push_d_q <= {a_msg, a_dom, a_seq, a_res, a_flg, ts_sec_q,
				             is_sync ? ns_plus : ns_plus - asym_in};
			end
		end
	end

	// Rewriter at the end of the delay line
	assign ridx    = ln_s[D-1] ? 11'h000 : r_cnt;
	assign act_cur = ln_s[D-1] ? PTS_ACT_NONE : r_act;
	assign crc_cur = ln_s[D-1] ? `PTS_CRC_INIT : crc_q;
	assign fcs     = ln_e[D-1] | (ln_v[D-2] & ln_e[D-2]) | (ln_v[D-3] & ln_e[D-3]) | (ln_v[D-4] & ln_e[D-4]);
	assign fcs_j   = ln_e[D-1] ? 2'h3 : (ln_e[D-2] ? 2'h2 : (ln_e[D-3] ? 2'h1 : 2'h0));
	assign a_rel   = ridx - r_off;
	assign a_k     = r_size - 4'h1 - a_rel[3:0];
	assign in_a    = (ridx >= r_off) && (ridx < r_off + {7'h00, r_size});
	assign in_cf   = r_cf_en && (ridx >= `PTS_OFF_CF) && (ridx <= `PTS_OFF_CF_END);
	assign cf_k    = 3'(`PTS_OFF_CF_END - ridx);

	always_comb begin
		rw_byte = ln_d[D-1];
		if (act_cur == PTS_ACT_NONE) begin
			rw_byte = ln_d[D-1];
		end else if (fcs) begin
			rw_byte = ~crc_cur[{fcs_j, 3'b000} +: 8];
		end else if (in_a) begin
			rw_byte = r_val[{a_k[2:0], 3'b000} +: 8];
		end else if (in_cf) begin
			rw_byte = r_cf[{cf_k, 3'b000} +: 8];
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			r_cnt <= 11'h000;
			crc_q <= `PTS_CRC_INIT;
		end else if (adv && ln_v[D-1]) begin
			r_cnt <= (ridx == `PTS_CNT_MAX) ? ridx : ridx + 11'h001;
			if (!fcs) begin
				crc_q <= crc_step(crc_cur, rw_byte);
			end
		end
	end

	pts_skid_buf u_buf (
		.clk_in    (clk_in),
		.rst_b_in  (rst_b_in),
		.up        (buf_if.snk),
		.valid_out (out_valid_out),
		.data_out  ({out_sof_out, out_eof_out, out_data_out}),
		.ready_in  (out_ready_in)
	);

	pts_ts_fifo u_fifo (
		.clk_in       (clk_in),
		.rst_b_in     (rst_b_in),
		.wr           (fifo_if.snk),
		.rd_in        (fifo_rd_in),
		.rd_data_out  (fifo_data_out),
		.rd_valid_out (fifo_valid_out),
		.empty_out    (fifo_empty_out)
	);

	property p_unmatched;
		@(posedge clk_in) disable iff (!rst_b_in)
		ln_v[D-1] && act_cur == PTS_ACT_NONE |-> rw_byte == ln_d[D-1];
	endproperty
	a_unmatched: assert property (p_unmatched) else $error("unmatched byte changed");

	property p_sof_sample;
		@(posedge clk_in) disable iff (!rst_b_in)
		acc && in_sof_in |=> ts_ns_q == $past(time_ns_in) && ts_sec_q == $past(time_sec_in);
	endproperty
	a_sof_sample: assert property (p_sof_sample) else $error("stamp not taken at sof");

	property p_ing_ptp;
		@(posedge clk_in) disable iff (!rst_b_in)
		decide && is_ptp && !egress_in |=> r_act == PTS_ACT_WRITE && r_off == `PTS_OFF_RES && r_size == `PTS_SZ_RES;
	endproperty
	a_ing_ptp: assert property (p_ing_ptp) else $error("ingress ptp target wrong");

	property p_ing_val;
		@(posedge clk_in) disable iff (!rst_b_in)
		decide && is_ptp && !egress_in |=> r_val[31:0] == $past(ns_minus) && r_cf_en == $past(is_sync);
	endproperty
	a_ing_val: assert property (p_ing_val) else $error("ingress ptp value wrong");

	property p_eg_ptp;
		@(posedge clk_in) disable iff (!rst_b_in)
		decide && is_ptp && egress_in |=> r_act == PTS_ACT_WSAVE && !r_cf_en && r_val == 64'h0;
	endproperty
	a_eg_ptp: assert property (p_eg_ptp) else $error("egress ptp action wrong");

	property p_save;
		@(posedge clk_in) disable iff (!rst_b_in)
		decide && is_ptp && egress_in |=> save_q && fifo_if.valid ##1 !save_q;
	endproperty
	a_save: assert property (p_save) else $error("save flag not one pulse");

	property p_fifo_ts;
		@(posedge clk_in) disable iff (!rst_b_in)
		decide && is_ptp && egress_in && !is_sync |=> push_d_q[31:0] == $past(ns_plus - asym_in);
	endproperty
	a_fifo_ts: assert property (p_fifo_ts) else $error("fifo time wrong");

	property p_zero;
		@(posedge clk_in) disable iff (!rst_b_in)
		ln_v[D-1] && act_cur == PTS_ACT_WSAVE && !fcs && ridx >= `PTS_OFF_RES && ridx <= `PTS_OFF_RES_END
		|-> rw_byte == 8'h00;
	endproperty
	a_zero: assert property (p_zero) else $error("reserved bytes not cleared");

	property p_oam_eg;
		@(posedge clk_in) disable iff (!rst_b_in)
		decide && is_oam && egress_in && a_opc != `PTS_OPC_DMT |=> r_off == `PTS_OFF_TXF && r_size == `PTS_SZ_TS;
	endproperty
	a_oam_eg: assert property (p_oam_eg) else $error("egress oam target wrong");

	property p_fcs;
		@(posedge clk_in) disable iff (!rst_b_in)
		ln_v[D-1] && ln_e[D-1] && act_cur != PTS_ACT_NONE |-> rw_byte == ~crc_cur[31:24];
	endproperty
	a_fcs: assert property (p_fcs) else $error("fcs not recomputed");
endmodule

/* pts_mac_sink.sv */
// Purpose: Far-side receiver model that stalls 2 of every 8 cycles
// Assumes: One frame in flight at a time
// Notes:   Store restarts on each first byte
`timescale 1ns/1ns
module pts_mac_sink (
	input  wire logic       clk_in,   // Clock
	input  wire logic       valid_in, // Byte valid
	input  wire logic [7:0] data_in,  // Byte
	input  wire logic       sof_in,   // First byte
	input  wire logic       eof_in,   // Last byte
	output logic            ready_out // Receiver ready
);
	logic [7:0] q[$];
	logic [2:0] cyc_q = 3'h0;
	int         eof_at = -1;
	initial ready_out = 1'b0;
	// Stalls slower than input, so the path buffer fills
	always @(negedge clk_in) begin
		cyc_q <= cyc_q + 3'h1;
		ready_out <= (cyc_q != 3'h0) && (cyc_q != 3'h5);
	end
	always @(posedge clk_in) begin
		if (valid_in && ready_out) begin
			if (sof_in) begin
				q = {};
				eof_at = -1;
			end
			q.push_back(data_in);
			if (eof_in)
				eof_at = q.size() - 1;
		end
	end
endmodule

/* pts_ts_path_tb.sv */
// Purpose: Self-checking bench for one time stamp path
// Assumes: Stimulus at falling edge
// Notes:   Expected frames built from input frame
`timescale 1ns/1ns
`include "pts_defines.svh"
`define CHK(n, ex, got) begin check_count++; if ((got) !== (ex)) begin error_cnt++; \
	$display("Error %s exp %h got %h", n, ex, got); end end
module pts_ts_path_tb;
	logic                  clk_in = 1'b0, rst_b_in = 1'b0, egress_in = 1'b0, fifo_rd_in = 1'b0;
	logic                  in_valid_in = 1'b0, in_sof_in = 1'b0, in_eof_in = 1'b0;
	logic [7:0]            in_data_in = 8'h00, out_data_out;
	logic [31:0]           ns = 32'h0100_0000, lc = 32'h0000_0100, asym = 32'h0000_0010, sec = 32'h1234_5678;
	logic                  in_ready_out, out_valid_out, out_sof_out, out_eof_out, out_ready_in;
	logic                  save_ts_out, fifo_valid_out, fifo_empty_out;
	logic [`PTS_SET_W-1:0] fifo_data_out;
	logic [7:0]            f[64], e[64];
	int                    error_cnt = 0, check_count = 0, saves = 0;

	pts_ts_path DUT (.clk_in(clk_in), .rst_b_in(rst_b_in), .egress_in(egress_in), .domain_in(8'h05),
		.mep_level_in(3'h2), .local_corr_in(lc), .asym_in(asym), .time_sec_in(sec), .time_ns_in(ns),
		.in_valid_in(in_valid_in), .in_data_in(in_data_in), .in_sof_in(in_sof_in), .in_eof_in(in_eof_in),
		.in_ready_out(in_ready_out), .out_valid_out(out_valid_out), .out_data_out(out_data_out),
		.out_sof_out(out_sof_out), .out_eof_out(out_eof_out), .out_ready_in(out_ready_in),
		.save_ts_out(save_ts_out), .fifo_rd_in(fifo_rd_in), .fifo_data_out(fifo_data_out),
		.fifo_valid_out(fifo_valid_out), .fifo_empty_out(fifo_empty_out));
	pts_mac_sink u_sink (.clk_in(clk_in), .valid_in(out_valid_out), .data_in(out_data_out),
		.sof_in(out_sof_out), .eof_in(out_eof_out), .ready_out(out_ready_in));

	always #5 clk_in = ~clk_in;
	always @(negedge clk_in) if (save_ts_out === 1'b1) saves++;

	function automatic logic [31:0] crc();
		logic [31:0] c;
		c = `PTS_CRC_INIT;
		for (int i = 0; i < 60; i++) begin
			c = c ^ {24'h0, e[i]};
			for (int k = 0; k < 8; k++)
				c = c[0] ? ((c >> 1) ^ `PTS_CRC_POLY) : (c >> 1);
		end
		return ~c;
	endfunction

	task automatic build(input logic [15:0] et, input logic [7:0] b14, b15, b18);
		ns = ns + 32'h0000_1010;
		for (int i = 0; i < 64; i++)
			f[i] = 8'(i * 37 + 11);
		{f[12], f[13], f[14], f[15], f[18]} = {et, b14, b15, b18};
		e = f;
	endtask

	task automatic run(input logic eg, input logic mod, input string nm);
		logic [31:0] c;
		int w;
		c = crc();
		if (mod) {e[60], e[61], e[62], e[63]} = {c[7:0], c[15:8], c[23:16], c[31:24]};
		egress_in = eg;
		for (int i = 0; i < 64; i++) begin
			in_valid_in = 1'b1;
			in_data_in = f[i];
			in_sof_in = (i == 0);
			in_eof_in = (i == 63);
			while (in_ready_out !== 1'b1) @(negedge clk_in);
			@(negedge clk_in);
		end
		in_valid_in = 1'b0;
		w = 0;
		while (u_sink.q.size() < 64 && w < 500) begin
			@(negedge clk_in);
			w++;
		end
		`CHK("out len", 64, u_sink.q.size())
		`CHK("eof at", 63, u_sink.eof_at)
		for (int i = 0; i < 64; i++)
			`CHK("out byte", e[i], u_sink.q[i])
		$display("Test %s done", nm);
	endtask

	task automatic t_ing_ptp();
		logic [63:0] cf;
		for (int m = 0; m < 2; m++) begin
			build(16'h88f7, 8'(m), 8'h02, 8'h05);
			{e[30], e[31], e[32], e[33]} = ns - lc;
			cf = 64'h0;
			for (int k = 22; k < 30; k++) cf = {cf[55:0], e[k]};
			if (m == 0) cf = cf + (64'(asym) << 16);
			for (int k = 29; k > 21; k--) begin
				e[k] = cf[7:0];
				cf = cf >> 8;
			end
			run(1'b0, 1'b1, "ingress ptp");
			`CHK("no save", 0, saves)
		end
	endtask

	task automatic t_eg_ptp();
		int          s0;
		logic [79:0] id;
		logic [63:0] tm;
		for (int m = 0; m < 2; m++) begin
			s0 = saves;
			build(16'h88f7, 8'(m), 8'h02, 8'h05);
			{e[30], e[31], e[32], e[33]} = 32'h0;
			run(1'b1, 1'b1, "egress ptp");
			`CHK("save", s0 + 1, saves)
			`CHK("not empty", 1'b0, fifo_empty_out)
			fifo_rd_in = 1'b1;
			@(negedge clk_in);
			fifo_rd_in = 1'b0;
			`CHK("rd valid", 1'b1, fifo_valid_out)
			id = {f[14], f[18], f[44], f[45], f[30], f[31], f[32], f[33], f[20], f[21]};
			tm = {sec, ns + lc - (m ? asym : 32'h0)};
			`CHK("id", id, fifo_data_out[143:64])
			`CHK("time", tm, fifo_data_out[63:0])
			`CHK("empty", 1'b1, fifo_empty_out)
		end
		fifo_rd_in = 1'b1;
		@(negedge clk_in);
		fifo_rd_in = 1'b0;
		`CHK("empty rd", 1'b0, fifo_valid_out)
	endtask

	task automatic t_oam();
		logic [7:0]  op[3] = '{8'h2d, 8'h2f, 8'h2e};
		logic [63:0] ts;
		int          o;
		for (int d = 0; d < 2; d++)
			for (int k = 0; k < 3; k++) begin
				build(16'h8902, 8'h40, op[k], 8'h00);
				for (int j = 19; j < 26; j++) begin
					f[j] = 8'h00;
					e[j] = 8'h00;
				end
				o = d ? (k == 2 ? 34 : 18) : (k == 2 ? 42 : 26);
				ts = {sec, d ? ns + lc : ns - lc};
				for (int j = 0; j < 8; j++) e[o + j] = ts[63 - 8 * j -: 8];
				run(1'(d), 1'b1, "oam");
			end
	endtask

	task automatic t_miss();
		int s0;
		// Foreign domain, then OAM of another level
		for (int m = 0; m < 2; m++) begin
			s0 = saves;
			if (m == 0)
				build(16'h88f7, 8'h00, 8'h02, 8'h06);
			else
				build(16'h8902, 8'h60, 8'h2d, 8'h00);
			run(1'b1, 1'b0, "unmatched");
			`CHK("miss empty", 1'b1, fifo_empty_out)
			`CHK("miss save", s0, saves)
		end
	endtask

	task automatic end_of_test();
		$display("Checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial begin
		repeat (5) @(posedge clk_in);
		@(negedge clk_in);
		rst_b_in = 1'b1;
		t_ing_ptp();
		t_eg_ptp();
		t_oam();
		t_miss();
		end_of_test();
	end
	// Twelve frames need about 15 us; margin of over six
	initial begin
		#100000;
		error_cnt++;
		end_of_test();
	end
endmodule
